// ### shared/fssr_params.svh
// Offsets, field positions, reset values and timing counts of the flash security status bank.
`ifndef FSSR_PARAMS_SVH
`define FSSR_PARAMS_SVH
`define FSSR_OFS_LOCK      8'h01
`define FSSR_OFS_PIDX      8'h02
`define FSSR_OFS_GUARD     8'h03
`define FSSR_OFS_CFG       8'h04
`define FSSR_SEC_ADDR      24'hff_fe0f
`define FSSR_SEC_PRELOAD   8'hff
`define FSSR_SEC_FAULT     8'hff
`define FSSR_KEY_HI        7
`define FSSR_KEY_LO        6
`define FSSR_LOCK_HI       1
`define FSSR_LOCK_LO       0
`define FSSR_KEY_ON        2'h2
`define FSSR_UNSECURED     2'h2
`define FSSR_BYPASS_BIT    7
`define FSSR_ACK_BIT       0
`define FSSR_WS_HI         3
`define FSSR_WS_LO         2
`define FSSR_WS_RESET      2'h3
`define FSSR_PIDX_RESET    2'h0
`define FSSR_SWITCH_CYCLES 4
`define FSSR_BYTE_ZERO     8'h00
`endif

// ### shared/fssr_pkg.sv
// Types shared by the flash security status bank.
package fssr_pkg;
    typedef struct packed {
        logic [1:0] key;
        logic [3:0] spare;
        logic [1:0] lock;
    } fssr_sec_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } fssr_bus_t;

    typedef enum logic [1:0] {
        FSSR_WS_IDLE   = 2'h0,
        FSSR_WS_SETTLE = 2'h1,
        FSSR_WS_APPLY  = 2'h3
    } fssr_ws_state_t;

    typedef enum logic {
        FSSR_LD_FETCH = 1'h0,
        FSSR_LD_DONE  = 1'h1
    } fssr_ld_state_t;
endpackage

// ### verification/fssr_flash_model.sv
// Flash model that answers the security byte fetch made at reset.
module fssr_flash_model (
    input  wire logic        clk_sys_i,
    input  wire logic        rst_n_i,
    input  wire logic        fetch_req_i,
    input  wire logic [23:0] fetch_addr_i,
    input  wire logic [7:0]  stored_i,
    input  wire logic        fault_i,
    input  wire logic [1:0]  delay_i,
    output logic             valid_o,
    output logic      [7:0]  byte_o,
    output logic             fault_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_r;
    wire        hit = (fetch_addr_i === 24'hff_fe0f);
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            wait_r <= 2'h0;
            valid_o <= 1'b0;
            byte_o <= 8'h5a;
            fault_o <= 1'b0;
        end
        else if (!fetch_req_i || valid_o)
        begin
            wait_r <= 2'h0;
            valid_o <= 1'b0;
            byte_o <= ~byte_o;
            fault_o <= ~fault_o;
        end
        else if (wait_r == delay_i)
        begin
            valid_o <= 1'b1;
            byte_o <= hit ? {stored_i[7:6], 4'hf, stored_i[1:0]} : 8'h00;
            fault_o <= fault_i;
        end
        else
            wait_r <= wait_r + 2'h1;
    end
endmodule

// ### verification/tb.sv
// Self-checking bench for the flash security status registers.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SW = 2;
    logic        clk_sys_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        unlock = 1'b0;
    logic        bypass = 1'b0;
    logic        cmd_done = 1'b1;
    logic [7:0]  stored = 8'hff;
    logic        fault = 1'b0;
    logic [1:0]  delay = 2'h0;
    wire  [7:0]  rdata;
    wire  [23:0] faddr;
    wire  [7:0]  sbyte;
    wire  [1:0]  pidx;
    wire  [1:0]  rwait;
    wire         req, valid, sfault, bk_en, secd, ack;
    int          bad_count = 0;
    int          n_compared = 0;
    logic [7:0]  rv, d;
    logic [1:0]  cur, v;
    logic        c;
    int          n;

    fssr_regs #(.SWITCH_CYCLES(SW)) fssr_regs_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .sec_fetch_req_o(req),
        .sec_fetch_addr_o(faddr), .sec_fetch_valid_i(valid), .sec_byte_i(sbyte),
        .sec_dbl_fault_i(sfault), .backdoor_unlock_i(unlock), .guard_bypass_i(bypass),
        .command_complete_flag_i(cmd_done), .backdoor_enabled_o(bk_en), .secured_o(secd),
        .param_index_field_o(pidx), .read_wait_o(rwait), .wait_switch_done_o(ack));
    fssr_flash_model fssr_flash_model_inst (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fetch_req_i(req), .fetch_addr_i(faddr),
        .stored_i(stored), .fault_i(fault), .delay_i(delay), .valid_o(valid),
        .byte_o(sbyte), .fault_o(sfault));

    initial
        forever #12.5 clk_sys_i = ~clk_sys_i;

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= dat;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 dat = rdata;
        @(posedge clk_sys_i);
    endtask

    task automatic wrd(input logic [7:0] a, input logic [7:0] dat, output logic [7:0] q);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= dat;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 q = rdata;
        @(posedge clk_sys_i);
    endtask

    task automatic do_reset(input logic [7:0] b, input logic f);
        int k;
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        stored <= b;
        fault <= f;
        delay <= 2'($urandom);
        repeat (4) @(posedge clk_sys_i);
        #1 check("reset wait", 24'(rwait), 24'h3);
        check("reset ack", 24'(ack), 24'h1);
        check("reset index", 24'(pidx), 24'h0);
        check("reset req", 24'(req), 24'h1);
        check("fetch addr", faddr, 24'hff_fe0f);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        k = 0;
        while (req !== 1'b0 && k < 20)
        begin
            @(posedge clk_sys_i);
            #1 k++;
        end
        check("fetch done", 24'(req), 24'h0);
        @(posedge clk_sys_i);
    endtask

    task automatic print_verdict;
        $display("Counts: %0d compared, %0d mismatched", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h5972));
        for (int i = 0; i < 16; i++)
        begin
            rv = 8'($urandom);
            do_reset({i[3:2], rv[5:2], i[1:0]}, 1'b0);
            rd(8'h01, d);
            check("lock", 24'(d), 24'({i[3:2], 4'hf, i[1:0]}));
            check("key", 24'(bk_en), 24'(i[3:2] == 2'h2));
            check("secured", 24'(secd), 24'(i[1:0] != 2'h2));
            wr(8'h01, ~d);
            rd(8'h01, d);
            check("lock ro", 24'(d), 24'({i[3:2], 4'hf, i[1:0]}));
            @(posedge clk_sys_i);
            unlock <= 1'b1;
            @(posedge clk_sys_i);
            unlock <= 1'b0;
            rd(8'h01, d);
            check("unlock", 24'(d), 24'({i[3:2], 4'hf, 2'h2}));
            check("unsecured", 24'(secd), 24'h0);
        end
        do_reset(8'($urandom), 1'b1);
        rd(8'h01, d);
        check("fault lock", 24'(d), 24'hff);
        check("fault key", 24'({bk_en, secd}), 24'h1);
        $display("Test security load done");
        for (int i = 0; i < 20; i++)
        begin
            rv = 8'($urandom);
            if (i[0])
                wrd(8'h02, rv, d);
            else
            begin
                wr(8'h02, rv);
                rd(8'h02, d);
            end
            check("index", 24'(d), 24'({6'h0, rv[1:0]}));
            check("index out", 24'(pidx), 24'(rv[1:0]));
        end
        wr(8'h09, 8'h00);
        rd(8'h09, d);
        check("unmapped", 24'({d, 6'h0, pidx}), 24'(rv[1:0]));
        $display("Test index done");
        for (int i = 0; i < 8; i++)
        begin
            rv = 8'($urandom);
            bypass <= rv[0];
            wr(8'h03, rv);
            rd(8'h03, d);
            check("status", 24'(d), 24'({rv[0], 6'h0, 1'b1}));
        end
        $display("Test status done");
        cur = 2'h3;
        for (int k = 0; k < 12; k++)
        begin
            rv = 8'($urandom);
            v = (k == 0) ? cur : rv[3:2];
            c = (k == 1) ? 1'b0 : (rv[4] | rv[5]);
            cmd_done <= c;
            wr(8'h04, {rv[7:4], v, rv[1:0]});
            #1 n = 0;
            if (c && v != cur)
            begin
                check("ack clear", 24'(ack), 24'h0);
                while (ack !== 1'b1 && n < 40)
                begin
                    check("old wait", 24'(rwait), 24'(cur));
                    @(posedge clk_sys_i);
                    #1 n++;
                end
                check("switch len", 24'(n), 24'(SW + 1));
                cur = v;
            end
            else
                check("ack kept", 24'(ack), 24'h1);
            check("wait used", 24'(rwait), 24'(cur));
            rd(8'h04, d);
            check("config", 24'(d), 24'({4'h0, cur, 2'h0}));
        end
        $display("Test wait switch done");
        print_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        bad_count++;
        print_verdict;
    end
endmodule

// ### verilog/fssr_regs.sv
// Flash security, parameter index and protection status registers.
//
// Design decision made here: the plain strobed port.
`include "fssr_params.svh"
module fssr_regs #(
    parameter int INDEX_W       = 2,
    parameter int WS_W          = 2,
    parameter int SWITCH_CYCLES = `FSSR_SWITCH_CYCLES
) (
    input  wire logic               clk_sys_i,
    input  wire logic               rst_n_i,
    input  wire logic [7:0]         addr_i,
    input  wire logic [7:0]         wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output logic      [7:0]         rdata_o,
    output logic                    sec_fetch_req_o,
    output logic      [23:0]        sec_fetch_addr_o,
    input  wire logic               sec_fetch_valid_i,
    input  wire logic [7:0]         sec_byte_i,
    input  wire logic               sec_dbl_fault_i,
    input  wire logic               backdoor_unlock_i,
    input  wire logic               guard_bypass_i,
    input  wire logic               command_complete_flag_i,
    output logic                    backdoor_enabled_o,
    output logic                    secured_o,
    output logic      [INDEX_W-1:0] param_index_field_o,
    output logic      [WS_W-1:0]    read_wait_o,
    output logic                    wait_switch_done_o
);
    fssr_pkg::fssr_bus_t      bus_w;
    fssr_pkg::fssr_sec_t      lock_r;
    fssr_pkg::fssr_sec_t      lock_nxt;
    fssr_pkg::fssr_ld_state_t ld_state_r;
    logic                     guard_bypass_flag_r;
    logic [INDEX_W-1:0]       pidx_nxt;
    logic [WS_W-1:0]          ws_field_w;
    logic [7:0]               rdata_nxt;

    assign bus_w = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // Address decode of the four byte registers.
    wire hit_lock_w  = bus_w.addr == `FSSR_OFS_LOCK;
    wire hit_pidx_w  = bus_w.addr == `FSSR_OFS_PIDX;
    wire hit_guard_w = bus_w.addr == `FSSR_OFS_GUARD;
    wire hit_cfg_w   = bus_w.addr == `FSSR_OFS_CFG;

    wire wr_pidx_w = bus_w.wr && hit_pidx_w;
    wire wr_cfg_w  = bus_w.wr && hit_cfg_w;

    // Security load at the end of reset, then backdoor unlock handling.
    wire loading_w  = ld_state_r == fssr_pkg::FSSR_LD_FETCH;
    wire load_now_w = loading_w && sec_fetch_valid_i;
    wire unlock_w   = !loading_w && backdoor_unlock_i;

    always_comb
    begin
        lock_nxt = lock_r;
        if (load_now_w)
            lock_nxt = sec_dbl_fault_i ? `FSSR_SEC_FAULT : sec_byte_i;
        else if (unlock_w)
            lock_nxt.lock = `FSSR_UNSECURED;
    end

    // Bus writes to the lock register never reach lock_nxt.
    assign pidx_nxt = wr_pidx_w ? bus_w.wdata[INDEX_W-1:0] : param_index_field_o;

    // Field views of the readable registers.
    wire [7:0] rd_lock_w  = lock_r;
    wire [7:0] rd_pidx_w  = {{(8 - INDEX_W){1'b0}}, param_index_field_o};
    wire [7:0] rd_guard_w = {guard_bypass_flag_r, 6'h00, wait_switch_done_o};
    wire [7:0] rd_cfg_w   = {4'h0, ws_field_w, 2'h0};

    // Read data stand in the one cycle after the strobe; unmapped reads return zero.
    assign rdata_nxt = !bus_w.rd  ? `FSSR_BYTE_ZERO :
                       hit_lock_w  ? rd_lock_w  :
                       hit_pidx_w  ? rd_pidx_w  :
                       hit_guard_w ? rd_guard_w :
                       hit_cfg_w   ? rd_cfg_w   : `FSSR_BYTE_ZERO;

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            ld_state_r       <= fssr_pkg::FSSR_LD_FETCH;
            sec_fetch_req_o  <= 1'b1;
            sec_fetch_addr_o <= `FSSR_SEC_ADDR;
            lock_r           <= `FSSR_SEC_PRELOAD;
        end
        else
        begin
            if (load_now_w)
            begin
                ld_state_r      <= fssr_pkg::FSSR_LD_DONE;
                sec_fetch_req_o <= 1'b0;
            end
            lock_r <= lock_nxt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            param_index_field_o <= `FSSR_PIDX_RESET;
            guard_bypass_flag_r <= 1'b0;
            rdata_o             <= `FSSR_BYTE_ZERO;
        end
        else
        begin
            param_index_field_o <= pidx_nxt;
            guard_bypass_flag_r <= guard_bypass_i;
            rdata_o             <= rdata_nxt;
        end
    end

    // Decoded security status, held in flip-flops for the outputs.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            backdoor_enabled_o <= 1'b0;
            secured_o          <= 1'b1;
        end
        else
        begin
            backdoor_enabled_o <= lock_nxt.key == `FSSR_KEY_ON;
            secured_o          <= lock_nxt.lock != `FSSR_UNSECURED;
        end
    end

    // Wait-state field, switch sequencing and acknowledge.
    fssr_wait_switch #(
        .WS_W          (WS_W),
        .SWITCH_CYCLES (SWITCH_CYCLES)
    ) u_wait_switch (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .ws_wr_i     (wr_cfg_w),
        .ws_data_i   (bus_w.wdata[`FSSR_WS_HI:`FSSR_WS_LO]),
        .cmd_idle_i  (command_complete_flag_i),
        .ws_field_o  (ws_field_w),
        .ws_active_o (read_wait_o),
        .ack_o       (wait_switch_done_o)
    );

    a_load_sec_byte: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load_now_w && !sec_dbl_fault_i |=> lock_r == $past(sec_byte_i))
        else $error("Security byte not loaded.");

    a_fault_sets_all: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load_now_w && sec_dbl_fault_i |=> lock_r == `FSSR_SEC_FAULT ##1 !backdoor_enabled_o)
        else $error("Fault did not secure the part.");

    a_lock_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.wr && hit_lock_w && !load_now_w && !unlock_w |=> $stable(lock_r))
        else $error("Lock register changed by a write.");

    a_key_decode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ##1 backdoor_enabled_o == (lock_r.key == `FSSR_KEY_ON))
        else $error("Backdoor enable decode wrong.");

    a_secure_decode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ##1 secured_o == (lock_r.lock != `FSSR_UNSECURED))
        else $error("Secured decode wrong.");

    a_unlock_forces: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        unlock_w |=> lock_r.lock == `FSSR_UNSECURED ##1 !secured_o)
        else $error("Unlock did not force the lock field.");

    a_pidx_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_pidx_w ##1 (bus_w.rd && hit_pidx_w && !bus_w.wr)
        |=> rdata_o == {{(8 - INDEX_W){1'b0}}, $past(bus_w.wdata[INDEX_W-1:0], 2)})
        else $error("Index readback wrong.");

    a_pidx_holds: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr_pidx_w |=> $stable(param_index_field_o))
        else $error("Index changed without a write.");

    a_guard_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_guard_w |=> rdata_o[6:1] == 6'h00
        && rdata_o[`FSSR_ACK_BIT] == $past(wait_switch_done_o))
        else $error("Protection status read wrong.");

    a_bypass_flag: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_guard_w ##1 1'b1 |-> rdata_o[`FSSR_BYPASS_BIT] == $past(guard_bypass_i, 2))
        else $error("Override bit does not follow the override state.");

    a_ack_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_cfg_w && command_complete_flag_i
        && bus_w.wdata[`FSSR_WS_HI:`FSSR_WS_LO] != ws_field_w |=> !wait_switch_done_o)
        else $error("Acknowledge not cleared by a change.");

    a_ack_returns: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(wait_switch_done_o) && !wr_cfg_w [*1] ##1 !wr_cfg_w [*8]
        |-> wait_switch_done_o)
        else $error("Acknowledge did not return.");

    a_ws_reset_max: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> ws_field_w == `FSSR_WS_RESET && read_wait_o == `FSSR_WS_RESET)
        else $error("Wait field not at maximum after reset.");

    a_reset_values: assert property (@(posedge clk_sys_i)
        !rst_n_i |=> param_index_field_o == `FSSR_PIDX_RESET && wait_switch_done_o)
        else $error("Index or acknowledge wrong after reset.");

    a_read_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !bus_w.rd |=> rdata_o == `FSSR_BYTE_ZERO)
        else $error("Read data outside the answer cycle.");

    a_req_drops: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load_now_w |=> !sec_fetch_req_o && !loading_w)
        else $error("Fetch request still raised after the load.");

    a_req_stays_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !sec_fetch_req_o |=> !sec_fetch_req_o)
        else $error("Second security fetch requested.");

    a_req_until_load: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sec_fetch_req_o && !sec_fetch_valid_i |=> sec_fetch_req_o)
        else $error("Fetch request dropped before the byte arrived.");

    a_fetch_addr_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sec_fetch_req_o |-> sec_fetch_addr_o == `FSSR_SEC_ADDR)
        else $error("Fetch address wrong.");

    a_fault_key_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        load_now_w && sec_dbl_fault_i |=> secured_o && !backdoor_enabled_o)
        else $error("Fault load left the part open.");

    a_lock_read_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_lock_w |=> rdata_o == $past(lock_r))
        else $error("Lock register read wrong.");

    a_lock_idle_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !load_now_w && !unlock_w |=> $stable(lock_r))
        else $error("Lock register changed without a load or unlock.");

    a_unlock_keeps_key: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        unlock_w |=> lock_r.key == $past(lock_r.key) && lock_r.spare == $past(lock_r.spare))
        else $error("Unlock touched bits other than the lock field.");

    a_unlock_too_early: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        loading_w && !sec_fetch_valid_i |=> $stable(lock_r))
        else $error("Lock register changed before the load.");

    a_pidx_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_pidx_w |=> param_index_field_o == $past(bus_w.wdata[INDEX_W-1:0]))
        else $error("Index write not taken.");

    a_pidx_upper_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_pidx_w |=> rdata_o[7:INDEX_W] == '0)
        else $error("Upper index bits not zero.");

    a_pidx_read_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_pidx_w |=> rdata_o[INDEX_W-1:0] == $past(param_index_field_o))
        else $error("Index read value wrong.");

    a_bypass_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_guard_w |=> rdata_o[`FSSR_BYPASS_BIT] == $past(guard_bypass_flag_r))
        else $error("Override bit read wrong.");

    a_same_ws_no_clr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_cfg_w && bus_w.wdata[`FSSR_WS_HI:`FSSR_WS_LO] == ws_field_w && wait_switch_done_o
        |=> wait_switch_done_o)
        else $error("Acknowledge cleared by an unchanged wait field.");

    a_ack_rise_match: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(wait_switch_done_o) |-> read_wait_o == ws_field_w)
        else $error("Acknowledge set before the new wait setting was in use.");

    a_wait_moves_ack: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $changed(read_wait_o) && $past(rst_n_i) |-> $rose(wait_switch_done_o))
        else $error("Wait setting changed without the acknowledge.");

    a_cfg_write_take: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_cfg_w && command_complete_flag_i
        |=> ws_field_w == $past(bus_w.wdata[`FSSR_WS_HI:`FSSR_WS_LO]))
        else $error("Wait field write not taken.");

    a_cfg_read_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && hit_cfg_w |=> rdata_o == {4'h0, $past(ws_field_w), 2'h0})
        else $error("Configuration read wrong.");

    a_busy_cfg_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_cfg_w && !command_complete_flag_i |=> $stable(ws_field_w))
        else $error("Wait field changed by a write during a command.");

    a_busy_ack_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_cfg_w && !command_complete_flag_i && wait_switch_done_o |=> wait_switch_done_o)
        else $error("Acknowledge cleared by a write during a command.");

    a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        bus_w.rd && !(hit_lock_w || hit_pidx_w || hit_guard_w || hit_cfg_w)
        |=> rdata_o == `FSSR_BYTE_ZERO)
        else $error("Unmapped read returned data.");
endmodule

// ### verilog/fssr_wait_switch.sv
// Wait-state field with its delayed switch and acknowledge.
`include "fssr_params.svh"
module fssr_wait_switch #(
    parameter int WS_W          = 2,
    parameter int SWITCH_CYCLES = `FSSR_SWITCH_CYCLES
) (
    input  wire logic            clk_sys_i,
    input  wire logic            rst_n_i,
    input  wire logic            ws_wr_i,
    input  wire logic [WS_W-1:0] ws_data_i,
    input  wire logic            cmd_idle_i,
    output logic      [WS_W-1:0] ws_field_o,
    output logic      [WS_W-1:0] ws_active_o,
    output logic                 ack_o
);
    localparam logic [7:0] CNT_LOAD = 8'(SWITCH_CYCLES - 1);

    fssr_pkg::fssr_ws_state_t state_r;
    fssr_pkg::fssr_ws_state_t state_nxt;
    logic [7:0]               cnt_r;
    wire                      take_w = ws_wr_i && cmd_idle_i && (ws_data_i != ws_field_o);
    wire                      done_w = (state_r == fssr_pkg::FSSR_WS_SETTLE) && (cnt_r == 8'h00);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            fssr_pkg::FSSR_WS_IDLE:   state_nxt = state_r;
            fssr_pkg::FSSR_WS_SETTLE: if (done_w) state_nxt = fssr_pkg::FSSR_WS_APPLY;
            fssr_pkg::FSSR_WS_APPLY:  state_nxt = fssr_pkg::FSSR_WS_IDLE;
            default:                  state_nxt = fssr_pkg::FSSR_WS_IDLE;
        endcase
        if (take_w)
            state_nxt = fssr_pkg::FSSR_WS_SETTLE;
    end

    // A new accepted change restarts the switch, so its clear outranks a pending set.
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            state_r     <= fssr_pkg::FSSR_WS_IDLE;
            cnt_r       <= 8'h00;
            ws_field_o  <= `FSSR_WS_RESET;
            ws_active_o <= `FSSR_WS_RESET;
            ack_o       <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= take_w ? CNT_LOAD : (done_w ? cnt_r : cnt_r - 8'h01);
            if (take_w)
            begin
                ws_field_o <= ws_data_i;
                ack_o      <= 1'b0;
            end
            else if (state_r == fssr_pkg::FSSR_WS_APPLY)
            begin
                ws_active_o <= ws_field_o;
                ack_o       <= 1'b1;
            end
        end
    end

    a_ack_sets_apply: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        done_w && !take_w ##1 !take_w |=> ack_o && (ws_active_o == ws_field_o))
        else $error("Acknowledge did not follow the switch.");
    a_old_ws_held: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ack_o ##1 !ack_o |-> $stable(ws_active_o))
        else $error("Wait setting changed while acknowledge was low.");
    a_busy_write_ign: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ws_wr_i && !cmd_idle_i |=> $stable(ws_field_o) && ($past(ack_o) -> ack_o))
        else $error("Wait field changed during a command.");
endmodule
